// ### logic/flash_seq_pkg.sv
`default_nettype none
package flash_seq_pkg;
   localparam logic [3:0]  CTRL1_OFS     = 4'h0;
   localparam logic [3:0]  CTRL2_OFS     = 4'h4;
   localparam logic [3:0]  CTRL3_OFS     = 4'h8;
   localparam logic [7:0]  KEY_WRITE     = 8'ha5;
   localparam logic [7:0]  KEY_READ      = 8'h96;
   localparam logic [7:0]  CTRL2_RESET   = 8'h42;
   localparam logic [15:0] STALL_OPCODE  = 16'h3fff;
   localparam int          C1_BLK        = 7;
   localparam int          C1_WR         = 6;
   localparam int          C1_MASS       = 2;
   localparam int          C1_ERASE      = 1;
   localparam int          C2_SEL_LO     = 6;
   localparam int          C3_BUSY       = 0;
   localparam int          C3_KEY_VIOL   = 1;
   localparam int          C3_ACCV       = 2;
   localparam int          C3_WAIT       = 3;
   localparam int          C3_EXIT       = 5;
   localparam logic [1:0]  SRC_AUX       = 2'h0;
   localparam logic [1:0]  SRC_MAIN      = 2'h1;
   localparam int          ADDR_W        = 11;
   localparam int          MEM_WORDS     = 1152;
   localparam logic [10:0] INFO_END      = 11'h080;
   localparam logic [10:0] MEM_END       = 11'h480;
   localparam logic [2:0]  MAIN_SEG_BASE = 3'h2;
   localparam logic [15:0] ERASE_TICKS_DEF = 16'h1388;
   localparam logic [15:0] PROG_TICKS    = 16'h0023;
   localparam logic [15:0] BLK_WORD_TICKS = 16'h0014;
   localparam logic [15:0] BLK_END_TICKS = 16'h0006;

   typedef enum {IDLE, ERASING, PROGRAM, BLK_WAIT, BLK_PROG, BLK_END} seq_state_e;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic              fetch;
      logic              from_flash;
      logic [1:0]        be;
      logic [ADDR_W-1:0] addr;
      logic [15:0]       wdata;
   } cpu_req_s;
endpackage : flash_seq_pkg
`default_nettype wire

// ### logic/flash_program_erase_sequencer.sv
// Notes on behaviour
// - Mass/erase bits pick segment, main or all
// - Erase starts on dummy write inside range
// - Busy during erase; busy and erase bits self-clear
// - Out-of-range dummy write ignored, no flag
// - Interrupts masked for whole erase
// - Erase from flash code stalls the CPU
// - Flash read or write while busy flags violation, except reads and in-block writes in block wait
// - Erased reads one; program only clears bits
// - Two 128-byte info, several 512-byte main segments
// - Block and write bits pick word or block
// - Interrupts masked during any programming
// - Busy set while programming, cleared after
// - Word write from flash code stalls CPU
// - Early flash access during word write violates
// - Blocks are 64 aligned bytes
// - Pump stays on through whole block
// - Busy through block; wait flag paces words
// - Block ends when block bit cleared, recovery
// - Timing clock from three sources, divided
// - Idle means read mode, generators off
// - Stalled fetches return jump-to-self opcode
// - Violation flag sticky until software clears
// - Register writes need key, else reset
// - Emergency exit aborts, clears mode bits
`default_nettype none
module flash_program_erase_sequencer
   import flash_seq_pkg::*;
#(
   parameter logic [15:0] ERASE_TICKS = ERASE_TICKS_DEF
)(
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire cpu_req_s    i_cpu,
   output logic      [15:0] o_cpu_rdata,
   output logic             o_cpu_stall,
   output logic             o_irq_mask,
   output logic             o_pump_on,
   output logic             o_system_reset,
   input  wire logic        i_auxiliary_clock,
   input  wire logic        i_submain_clock,
   input  wire logic        i_main_clock
);
   seq_state_e  state_r;
   seq_state_e  state_nxt;
   logic        busy_r;
   logic        stall_r;
   logic        mask_r;
   logic        pump_r;
   logic        blk_r;
   logic        wr_r;
   logic        mass_r;
   logic        erase_r;
   logic        accv_r;
   logic        key_viol_r;
   logic        sysrst_r;
   logic [7:0]  ctrl2_r;
   logic [15:0] count_r;
   logic [5:0]  div_cnt_r;
   logic [ADDR_W-1:0] op_addr_r;
   logic [15:0] op_data_r;
   logic [5:0]  blk_base_r;
   logic [15:0] cpu_rdata_r;
   logic        avs_wait_r;
   logic [31:0] avs_rdata_r;
   logic [15:0] flash_mem_r [MEM_WORDS];
   logic [2:0]  src_raw;
   logic [2:0]  src_rise;

   // Timing source synchronisers and edge detect
   assign src_raw = {i_main_clock, i_submain_clock, i_auxiliary_clock};
   genvar g;
   for (g = 0; g < 3; g++)
   begin : g_src
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      always_ff @(posedge i_clock)
      begin
         if (i_reset)
         begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            lvl_r <= 1'b0;
         end
         else
         begin
            s1_r <= src_raw[g];
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
               lvl_r <= s3_r;
         end
      end
      assign src_rise[g] = s2_r & s3_r & ~lvl_r;
   end

   logic       src_tick;
   logic       ftg_tick;
   logic       phase_done;
   logic [1:0] src_sel;
   assign src_sel    = ctrl2_r[C2_SEL_LO+1:C2_SEL_LO];
   assign src_tick   = (src_sel == SRC_AUX) ? src_rise[0] :
                       (src_sel == SRC_MAIN) ? src_rise[2] : src_rise[1];
   assign ftg_tick   = busy_r & src_tick & (div_cnt_r == ctrl2_r[5:0]);
   assign phase_done = ftg_tick & (count_r == 16'h0001);

   // Divider runs only while an operation is active
   always_ff @(posedge i_clock)
   begin
      if (i_reset || !busy_r)
         div_cnt_r <= 6'h00;
      else if (ftg_tick)
         div_cnt_r <= 6'h00;
      else if (src_tick)
         div_cnt_r <= div_cnt_r + 6'h01;
   end

   // CPU side decode
   logic cpu_hit;
   logic cpu_wr;
   logic cpu_rd;
   logic cpu_fetch;
   logic erase_sel;
   logic in_range;
   logic start_erase;
   logic start_prog;
   logic start_blk;
   logic blk_next;
   logic blk_close;
   logic blk_state;
   assign cpu_hit   = i_cpu.valid & (i_cpu.addr < MEM_END);
   assign cpu_wr    = cpu_hit & i_cpu.write;
   assign cpu_rd    = cpu_hit & ~i_cpu.write & ~i_cpu.fetch;
   assign cpu_fetch = cpu_hit & ~i_cpu.write & i_cpu.fetch;
   assign erase_sel = mass_r | erase_r;
   assign in_range  = ~(mass_r & ~erase_r & (i_cpu.addr < INFO_END));
   assign start_erase = (state_r == IDLE) & cpu_wr & erase_sel & ~wr_r & in_range;
   assign start_prog  = (state_r == IDLE) & cpu_wr & wr_r & ~blk_r & ~erase_sel;
   assign start_blk   = (state_r == IDLE) & cpu_wr & wr_r & blk_r & ~erase_sel
                        & ~i_cpu.from_flash;
   assign blk_next  = (state_r == BLK_WAIT) & blk_r & cpu_wr
                      & (i_cpu.addr[ADDR_W-1:5] == blk_base_r);
   assign blk_close = (state_r == BLK_WAIT) & ~blk_r;
   assign blk_state = (state_r == BLK_WAIT) | (state_r == BLK_PROG) | (state_r == BLK_END);

   // Register bus decode
   logic reg_wr;
   logic key_ok;
   logic c1_wr;
   logic c2_wr;
   logic c3_wr;
   logic exit_hit;
   logic accv_set;
   logic accv_clr;
   assign reg_wr   = ~avs_wait_r & i_avs_write;
   assign key_ok   = i_avs_writedata[15:8] == KEY_WRITE;
   assign c1_wr    = reg_wr & key_ok & (i_avs_address == CTRL1_OFS);
   assign c2_wr    = reg_wr & key_ok & (i_avs_address == CTRL2_OFS);
   assign c3_wr    = reg_wr & key_ok & (i_avs_address == CTRL3_OFS);
   assign exit_hit = c3_wr & i_avs_writedata[C3_EXIT];
   assign accv_clr = c3_wr & ~i_avs_writedata[C3_ACCV];
   assign accv_set = (busy_r & (state_r != BLK_WAIT) & (cpu_wr | cpu_rd))
                   | (blk_state & cpu_fetch)
                   | ((state_r == BLK_WAIT) & cpu_wr & ~blk_next)
                   | ((state_r == IDLE) & cpu_wr & ~wr_r & ~erase_sel)
                   | (c1_wr & busy_r & (state_r != BLK_WAIT))
                   | (c2_wr & busy_r);

   // Sequencer
   always_comb
   begin
      state_nxt = state_r;
      if (exit_hit)
         state_nxt = IDLE;
      else
         case (state_r)
            IDLE:
            begin
               if (start_erase)
                  state_nxt = ERASING;
               else if (start_prog)
                  state_nxt = PROGRAM;
               else if (start_blk)
                  state_nxt = BLK_PROG;
            end
            ERASING, PROGRAM, BLK_END:
            begin
               if (phase_done)
                  state_nxt = IDLE;
            end
            BLK_PROG:
            begin
               if (phase_done)
                  state_nxt = BLK_WAIT;
            end
            BLK_WAIT:
            begin
               if (blk_close)
                  state_nxt = BLK_END;
               else if (blk_next)
                  state_nxt = BLK_PROG;
            end
            default: state_nxt = IDLE;
         endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         state_r <= IDLE;
         busy_r  <= 1'b0;
         mask_r  <= 1'b0;
         pump_r  <= 1'b0;
         stall_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         busy_r  <= state_nxt != IDLE;
         mask_r  <= state_nxt != IDLE;
         pump_r  <= (state_nxt != IDLE) && (state_nxt != BLK_END);
         stall_r <= (state_nxt != IDLE)
                    && (stall_r || ((start_erase || start_prog) && i_cpu.from_flash));
      end
   end

   // Phase timer in timing generator ticks
   always_ff @(posedge i_clock)
   begin
      if (i_reset || exit_hit)
         count_r <= 16'h0000;
      else if (start_erase)
         count_r <= ERASE_TICKS;
      else if (start_prog)
         count_r <= PROG_TICKS;
      else if (start_blk || blk_next)
         count_r <= BLK_WORD_TICKS;
      else if (blk_close)
         count_r <= BLK_END_TICKS;
      else if (ftg_tick && count_r != 16'h0000)
         count_r <= count_r - 16'h0001;
   end

   // Operation address and data capture
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         op_addr_r  <= '0;
         op_data_r  <= 16'hffff;
         blk_base_r <= 6'h00;
      end
      else if (start_erase || start_prog || start_blk || blk_next)
      begin
         op_addr_r <= i_cpu.addr;
         op_data_r <= {i_cpu.be[1] ? i_cpu.wdata[15:8] : 8'hff,
                       i_cpu.be[0] ? i_cpu.wdata[7:0] : 8'hff};
         if (start_blk)
            blk_base_r <= i_cpu.addr[ADDR_W-1:5];
      end
   end

   function automatic logic [2:0] seg_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] m;
      m = a - INFO_END;
      if (a < INFO_END)
         return {2'b00, a[6]};
      return MAIN_SEG_BASE + m[10:8];
   endfunction : seg_of

   // Flash array; starts erased
   logic prog_apply;
   logic erase_apply;
   logic [15:0] old_word;
   assign prog_apply  = phase_done & ((state_r == PROGRAM) | (state_r == BLK_PROG));
   assign erase_apply = phase_done & (state_r == ERASING);
   assign old_word    = flash_mem_r[op_addr_r];
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         for (int i = 0; i < MEM_WORDS; i++)
            flash_mem_r[i] <= 16'hffff;
      end
      else if (erase_apply)
      begin
         for (int i = 0; i < MEM_WORDS; i++)
            case ({mass_r, erase_r})
               2'b01:
                  if (seg_of(ADDR_W'(i)) == seg_of(op_addr_r))
                     flash_mem_r[i] <= 16'hffff;
               2'b10:
                  if (ADDR_W'(i) >= INFO_END)
                     flash_mem_r[i] <= 16'hffff;
               default: flash_mem_r[i] <= 16'hffff;
            endcase
      end
      else if (prog_apply)
         flash_mem_r[op_addr_r] <= old_word & op_data_r;
   end

   // CPU read path
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         cpu_rdata_r <= 16'h0000;
      else if (cpu_rd || cpu_fetch)
         cpu_rdata_r <= busy_r ? STALL_OPCODE : flash_mem_r[i_cpu.addr];
   end

   // Control bits
   always_ff @(posedge i_clock)
   begin
      if (i_reset || exit_hit)
      begin
         blk_r   <= 1'b0;
         wr_r    <= 1'b0;
         mass_r  <= 1'b0;
         erase_r <= 1'b0;
      end
      else if (erase_apply)
      begin
         mass_r  <= 1'b0;
         erase_r <= 1'b0;
      end
      else if (c1_wr && (!busy_r || state_r == BLK_WAIT))
      begin
         blk_r   <= i_avs_writedata[C1_BLK];
         wr_r    <= i_avs_writedata[C1_WR];
         mass_r  <= i_avs_writedata[C1_MASS];
         erase_r <= i_avs_writedata[C1_ERASE];
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         ctrl2_r <= CTRL2_RESET;
      else if (c2_wr && !busy_r)
         ctrl2_r <= i_avs_writedata[7:0];
   end

   // Sticky flags and a one-cycle reset pulse; a set wins over a clear
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         accv_r   <= 1'b0;
         key_viol_r <= 1'b0;
         sysrst_r <= 1'b0;
      end
      else
      begin
         accv_r   <= accv_set | (accv_r & ~accv_clr);
         key_viol_r <= (reg_wr & ~key_ok)
                       | (key_viol_r & ~(c3_wr & ~i_avs_writedata[C3_KEY_VIOL]));
         sysrst_r <= reg_wr & ~key_ok;
      end
   end

   // Avalon slave, one wait cycle per access
   logic [7:0] reg_low;
   always_comb
   begin
      case (i_avs_address)
         CTRL1_OFS: reg_low = {blk_r, wr_r, 3'h0, mass_r, erase_r, 1'b0};
         CTRL2_OFS: reg_low = ctrl2_r;
         CTRL3_OFS: reg_low = {4'h0, state_r == BLK_WAIT, accv_r, key_viol_r, busy_r};
         default:   reg_low = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         avs_wait_r  <= 1'b1;
         avs_rdata_r <= 32'h00000000;
      end
      else
      begin
         avs_wait_r <= ~((i_avs_read | i_avs_write) & avs_wait_r);
         if (i_avs_read && avs_wait_r)
            avs_rdata_r <= (reg_low == 8'h00 && i_avs_address != CTRL1_OFS
                            && i_avs_address != CTRL2_OFS && i_avs_address != CTRL3_OFS)
                           ? 32'h00000000 : {16'h0000, KEY_READ, reg_low};
      end
   end

   assign o_avs_readdata    = avs_rdata_r;
   assign o_avs_waitrequest = avs_wait_r;
   assign o_cpu_rdata       = cpu_rdata_r;
   assign o_cpu_stall       = stall_r;
   assign o_irq_mask        = mask_r;
   assign o_pump_on         = pump_r;
   assign o_system_reset    = sysrst_r;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   a_erase_busy: assert property (start_erase |=> busy_r && o_irq_mask)
      else $error("Busy or mask missing after erase start");
   a_erase_clear: assert property (erase_apply |=> !busy_r && !mass_r && !erase_r)
      else $error("Erase end did not clear busy and erase bits");
   a_ignore_write: assert property ((state_r == IDLE) && cpu_wr && erase_sel && !in_range
                                    && !accv_r |=> state_r == IDLE && !accv_r)
      else $error("Out-of-range dummy write had an effect");
   a_no_raise: assert property (prog_apply
                                |=> (flash_mem_r[$past(op_addr_r)] & ~$past(old_word)) == 16'h0000)
      else $error("Programming raised a bit");
   a_stall_start: assert property ((start_erase || start_prog) && i_cpu.from_flash
                                   |=> o_cpu_stall throughout busy_r [*2])
      else $error("CPU not stalled for operation from flash");
   a_stall_release: assert property (!busy_r |-> !o_cpu_stall)
      else $error("Stall outlived busy");
   a_fetch_opcode: assert property (busy_r && cpu_fetch |=> o_cpu_rdata == STALL_OPCODE)
      else $error("Fetch while busy did not return jump-to-self");
   a_ram_access: assert property (busy_r && cpu_rd && state_r != BLK_WAIT |=> accv_r)
      else $error("Access while busy not flagged");
   a_av_sticky: assert property (accv_r && !accv_clr |=> accv_r)
      else $error("Violation flag dropped by itself");
   a_key_reset: assert property (reg_wr && !key_ok |=> key_viol_r && o_system_reset)
      else $error("Bad key did not flag and reset");
   a_exit_abort: assert property (exit_hit |=> state_r == IDLE && !busy_r
                                  && !blk_r && !wr_r)
      else $error("Emergency exit did not abort");
   a_blk_pump: assert property (state_r == BLK_WAIT |-> o_pump_on && busy_r)
      else $error("Pump or busy off inside block");
   a_idle_quiet: assert property (state_r == IDLE ##1 state_r == IDLE
                                  |-> !o_pump_on && div_cnt_r == 6'h00)
      else $error("Generators active while idle");
   a_blk_align: assert property ((state_r == BLK_WAIT) && cpu_wr
                                 && i_cpu.addr[ADDR_W-1:5] != blk_base_r |=> accv_r)
      else $error("Write outside block not flagged");

   c_erase: cover property (start_erase ##[1:1000] erase_apply);
   c_flash_prog: cover property (start_prog && i_cpu.from_flash);
   c_block_end: cover property (blk_close ##[1:1000] state_r == IDLE);
   c_exit: cover property (busy_r && exit_hit);
endmodule : flash_program_erase_sequencer
`default_nettype wire

// ### verification/cpu_model.sv
`default_nettype none
module cpu_model
   import flash_seq_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic [15:0] i_rdata,
   output var  cpu_req_s    o_req
);
   timeunit 1ns;
   timeprecision 1ns;

   initial o_req = '0;

   // One access per call; released lines show inverted values
   task automatic acc(input logic w, input logic f, input logic ff,
                      input logic [ADDR_W-1:0] a, input logic [15:0] wd,
                      output logic [15:0] rq);
      o_req <= '{valid: 1'b1, write: w, fetch: f, from_flash: ff, be: 2'h3,
                 addr: a, wdata: wd};
      @(posedge i_clock);
      o_req <= '{valid: 1'b0, write: ~w, fetch: ~f, from_flash: ~ff, be: 2'h0,
                 addr: ~a, wdata: ~wd};
      @(posedge i_clock);
      rq = i_rdata;
   endtask : acc
endmodule : cpu_model
`default_nettype wire

// ### verification/tb_top.sv
`default_nettype none
module tb_top
   import flash_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clock      = 1'b0;
   logic        reset      = 1'b1;
   logic [3:0]  av_addr    = 4'h0;
   logic        av_read    = 1'b0;
   logic        av_write   = 1'b0;
   logic [31:0] av_wdata   = 32'h0;
   logic [31:0] av_rdata;
   logic        av_wait;
   cpu_req_s    cpu_req;
   logic [15:0] cpu_rdata;
   logic        stall;
   logic        irq_mask;
   logic        pump;
   logic        sys_rst;
   logic        rst_seen   = 1'b0;
   logic [4:0]  div_cnt    = 5'h0;
   int          err_total  = 0;
   int          n_compared = 0;
   logic [31:0] q;
   logic [15:0] d;

   initial
   begin
      forever #10 clock = ~clock;
   end

   // Slow timing sources and reset pulse capture
   always @(posedge clock)
   begin
      div_cnt <= div_cnt + 5'h1;
      if (sys_rst === 1'b1)
         rst_seen <= 1'b1;
   end

   flash_program_erase_sequencer #(.ERASE_TICKS(16'h0004)) i_dut (
      .i_clock(clock), .i_reset(reset), .i_avs_address(av_addr),
      .i_avs_read(av_read), .i_avs_write(av_write), .i_avs_writedata(av_wdata),
      .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_cpu(cpu_req),
      .o_cpu_rdata(cpu_rdata), .o_cpu_stall(stall), .o_irq_mask(irq_mask),
      .o_pump_on(pump), .o_system_reset(sys_rst), .i_auxiliary_clock(div_cnt[3]),
      .i_submain_clock(div_cnt[4]), .i_main_clock(div_cnt[2]));

   cpu_model i_cpu_model (.i_clock(clock), .i_rdata(cpu_rdata), .o_req(cpu_req));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rq);
      int n;
      n = 0;
      av_addr  <= a;
      av_wdata <= wd;
      av_read  <= ~wr;
      av_write <= wr;
      @(posedge clock);
      while (av_wait !== 1'b0 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= 20)
         err_total++;
      rq = av_rdata;
      av_read  <= 1'b0;
      av_write <= 1'b0;
      @(posedge clock);
   endtask : bus

   task automatic rd(input logic [3:0] a, output logic [31:0] rq);
      bus(1'b0, a, 32'h0, rq);
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      logic [31:0] x;
      bus(1'b1, a, {16'h0, KEY_WRITE, v}, x);
   endtask : wr

   task automatic poll(input int b, input logic v);
      logic [31:0] x;
      int n;
      n = 0;
      rd(CTRL3_OFS, x);
      while (x[b] !== v && n < 400)
      begin
         rd(CTRL3_OFS, x);
         n++;
      end
      chk("ctrl3 poll", {31'h0, v}, {31'h0, x[b]});
   endtask : poll

   task automatic t_regs;
      rd(CTRL3_OFS, q);
      chk("ctrl3 reset", {16'h0, KEY_READ, 8'h00}, q);
      rd(CTRL2_OFS, q);
      chk("ctrl2 reset", {16'h0, KEY_READ, CTRL2_RESET}, q);
      rd(4'hc, q);
      chk("unmapped", 32'h0, q);
      bus(1'b1, CTRL1_OFS, 32'h0000_0040, q);
      repeat (2) @(posedge clock);
      chk("sys reset", 32'h1, {31'h0, rst_seen});
      rd(CTRL1_OFS, q);
      chk("ctrl1 kept", {16'h0, KEY_READ, 8'h00}, q);
      rd(CTRL3_OFS, q);
      chk("key flag", 32'h1, {31'h0, q[C3_KEY_VIOL]});
      wr(CTRL3_OFS, 8'h00);
      wr(CTRL2_OFS, {SRC_MAIN, 6'h00});
      $display("test regs done");
   endtask : t_regs

   task automatic t_word;
      wr(CTRL1_OFS, 8'h40);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h100, 16'h0123, d);
      chk("word ctl", 32'h3, {29'h0, stall, irq_mask, pump});
      poll(C3_BUSY, 1'b0);
      chk("word idle", 32'h0, {30'h0, irq_mask, pump});
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h100, 16'h3a55, d);
      poll(C3_BUSY, 1'b0);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h180, 16'h5a5a, d);
      poll(C3_BUSY, 1'b0);
      wr(CTRL1_OFS, 8'h00);
      i_cpu_model.acc(1'b0, 1'b0, 1'b0, 11'h100, 16'h0, d);
      chk("and data", 32'h0001, {16'h0, d});
      $display("test word done");
   endtask : t_word

   task automatic t_erase;
      wr(CTRL1_OFS, 8'h02);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h100, 16'h0, d);
      chk("erase ctl", 32'h3, {29'h0, stall, irq_mask, pump});
      poll(C3_BUSY, 1'b0);
      chk("mask off", 32'h0, {31'h0, irq_mask});
      rd(CTRL1_OFS, q);
      chk("erase bits", {16'h0, KEY_READ, 8'h00}, q);
      i_cpu_model.acc(1'b0, 1'b0, 1'b0, 11'h100, 16'h0, d);
      chk("erased", 32'hffff, {16'h0, d});
      i_cpu_model.acc(1'b0, 1'b0, 1'b0, 11'h180, 16'h0, d);
      chk("next seg", 32'h5a5a, {16'h0, d});
      $display("test erase done");
   endtask : t_erase

   task automatic t_mass;
      wr(CTRL1_OFS, 8'h04);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h010, 16'h0, d);
      rd(CTRL3_OFS, q);
      chk("ignored", {16'h0, KEY_READ, 8'h00}, q);
      wr(CTRL2_OFS, 8'h80);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h180, 16'h0, d);
      repeat (60) @(posedge clock);
      rd(CTRL3_OFS, q);
      chk("submain slow", 32'h1, {31'h0, q[C3_BUSY]});
      poll(C3_BUSY, 1'b0);
      i_cpu_model.acc(1'b0, 1'b0, 1'b0, 11'h180, 16'h0, d);
      chk("mass", 32'hffff, {16'h0, d});
      wr(CTRL2_OFS, {SRC_AUX, 6'h01});
      wr(CTRL1_OFS, 8'h06);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h010, 16'h0, d);
      repeat (60) @(posedge clock);
      rd(CTRL3_OFS, q);
      chk("aux divided", 32'h1, {31'h0, q[C3_BUSY]});
      poll(C3_BUSY, 1'b0);
      wr(CTRL2_OFS, {SRC_MAIN, 6'h00});
      rd(CTRL1_OFS, q);
      chk("all bits", {16'h0, KEY_READ, 8'h00}, q);
      $display("test mass done");
   endtask : t_mass

   task automatic t_flash;
      wr(CTRL1_OFS, 8'h02);
      i_cpu_model.acc(1'b1, 1'b0, 1'b1, 11'h100, 16'h0, d);
      chk("stall on", 32'h1, {31'h0, stall});
      i_cpu_model.acc(1'b0, 1'b1, 1'b1, 11'h101, 16'h0, d);
      chk("jump self", {16'h0, STALL_OPCODE}, {16'h0, d});
      poll(C3_BUSY, 1'b0);
      chk("stall off", 32'h0, {31'h0, stall});
      rd(CTRL3_OFS, q);
      chk("fetch noflag", 32'h0, {31'h0, q[C3_ACCV]});
      i_cpu_model.acc(1'b0, 1'b1, 1'b1, 11'h100, 16'h0, d);
      chk("resume", 32'hffff, {16'h0, d});
      wr(CTRL1_OFS, 8'h40);
      i_cpu_model.acc(1'b1, 1'b0, 1'b1, 11'h300, 16'h1234, d);
      chk("word stall", 32'h1, {31'h0, stall});
      poll(C3_BUSY, 1'b0);
      chk("word resume", 32'h0, {31'h0, stall});
      wr(CTRL1_OFS, 8'h00);
      i_cpu_model.acc(1'b0, 1'b0, 1'b0, 11'h300, 16'h0, d);
      chk("word data", 32'h1234, {16'h0, d});
      $display("test flash done");
   endtask : t_flash

   task automatic t_block;
      wr(CTRL1_OFS, 8'hc0);
      i_cpu_model.acc(1'b1, 1'b0, 1'b1, 11'h200, 16'h0, d);
      rd(CTRL3_OFS, q);
      chk("blk flash", {16'h0, KEY_READ, 8'h00}, q);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h200, 16'h1111, d);
      poll(C3_WAIT, 1'b1);
      chk("blk pump", 32'h3, {30'h0, irq_mask, pump});
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h201, 16'h2222, d);
      poll(C3_WAIT, 1'b1);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h220, 16'h3333, d);
      rd(CTRL3_OFS, q);
      chk("out block", 32'h1, {31'h0, q[C3_ACCV]});
      wr(CTRL3_OFS, 8'h00);
      chk("pump held", 32'h1, {31'h0, pump});
      wr(CTRL1_OFS, 8'h00);
      rd(CTRL3_OFS, q);
      chk("recovery", 32'h1, {31'h0, q[C3_BUSY]});
      poll(C3_BUSY, 1'b0);
      i_cpu_model.acc(1'b0, 1'b0, 1'b0, 11'h201, 16'h0, d);
      chk("blk data", 32'h2222, {16'h0, d});
      i_cpu_model.acc(1'b0, 1'b0, 1'b0, 11'h220, 16'h0, d);
      chk("blk outside", 32'hffff, {16'h0, d});
      $display("test block done");
   endtask : t_block

   task automatic t_emergency_exit;
      wr(CTRL1_OFS, 8'h02);
      i_cpu_model.acc(1'b1, 1'b0, 1'b0, 11'h200, 16'h0, d);
      i_cpu_model.acc(1'b0, 1'b0, 1'b0, 11'h200, 16'h0, d);
      chk("busy read", {16'h0, STALL_OPCODE}, {16'h0, d});
      wr(CTRL3_OFS, 8'h24);
      rd(CTRL3_OFS, q);
      chk("abort", 32'h4, {29'h0, q[C3_ACCV], 1'b0, q[C3_BUSY]});
      rd(CTRL1_OFS, q);
      chk("abort bits", {16'h0, KEY_READ, 8'h00}, q);
      chk("abort pump", 32'h0, {30'h0, irq_mask, pump});
      $display("test emergency_exit done");
   endtask : t_emergency_exit

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   initial
   begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_regs;
      t_word;
      t_erase;
      t_mass;
      t_flash;
      t_block;
      t_emergency_exit;
      end_sim;
   end

   initial
   begin
      repeat (40000) @(posedge clock);
      err_total++;
      end_sim;
   end
endmodule : tb_top
`default_nettype wire
